// ---- common/dcc_pkg.sv ----
// Shared constants for the daisy chain command, response and kickoff timing block
`default_nettype none
package dcc_pkg;
   // ********************************
   // Stack positions
   // ********************************
   localparam int         POS_W      = 4;
   localparam logic [3:0] MASTER_POS = 4'h1;
   localparam logic [3:0] POS_TWO    = 4'h2;
   localparam logic [3:0] POS_ONE    = 4'h1;
   // ********************************
   // Command byte layout
   // ********************************
   localparam int         OP_MSB     = 7;
   localparam int         OP_LSB     = 4;
   localparam logic [3:0] OP_SCAN    = 4'h1;
   localparam logic [3:0] OP_MEASURE = 4'h2;
   localparam logic [7:0] BYTE_ZERO  = 8'h00;
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam logic [2:0] BIT_ONE    = 3'h1;
   // ********************************
   // Response kinds and lengths in bytes
   // ********************************
   localparam logic [2:0] RSP_REG    = 3'h0;
   localparam logic [2:0] RSP_VOLT   = 3'h1;
   localparam logic [2:0] RSP_TEMP   = 3'h2;
   localparam logic [2:0] RSP_FAULT  = 3'h3;
   localparam logic [2:0] RSP_SETUP  = 3'h4;
   localparam logic [5:0] LEN_REG    = 6'h04;
   localparam logic [5:0] LEN_VOLT   = 6'h28;
   localparam logic [5:0] LEN_TEMP   = 6'h16;
   localparam logic [5:0] LEN_FAULT  = 6'h16;
   localparam logic [5:0] LEN_SETUP  = 6'h2b;
   // ********************************
   // Measurement phase lengths in clock cycles
   // ********************************
   localparam int         INIT_CYC   = 16;
   localparam int         MEAS_CYC   = 1000;
   localparam int         POST_CYC   = 64;
   localparam int         CNT_W      = 16;
endpackage
`default_nettype wire

// ---- rtl/dcc_afifo.sv ----
// Two-entry dual-clock buffer with gray-coded pointers
`default_nettype none
module dcc_afifo #(
   parameter int W  = 9,
   parameter int AW = 1
) (
   // Write side
   input  wire logic         wclk,
   input  wire logic         wrst_n,
   input  wire logic         w_valid,
   input  wire logic [W-1:0] w_data,
   output logic              w_ready,
   // Read side
   input  wire logic         rclk,
   input  wire logic         rrst_n,
   output logic              r_valid,
   output logic [W-1:0]      r_data,
   input  wire logic         r_ready
);
   localparam logic [AW:0] FULL_X = (AW+1)'(3) << (AW-1);
   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] s1;
      logic [AW:0] s2;
   } dcc_ptr_t;
   dcc_ptr_t       w_r, w_nxt, r_r, r_nxt;
   logic [W-1:0]   mem [2**AW];

   assign w_ready = (w_r.gray != (w_r.s2 ^ FULL_X));
   assign r_valid = (r_r.gray != r_r.s2);
   assign r_data  = mem[r_r.bin[AW-1:0]];

   always_comb begin
      w_nxt = w_r;
      w_nxt.s1 = r_r.gray;
      w_nxt.s2 = w_r.s1;
      if (w_valid && w_ready) begin
         w_nxt.bin  = w_r.bin + 1'b1;
         w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
      end
      r_nxt = r_r;
      r_nxt.s1 = w_r.gray;
      r_nxt.s2 = r_r.s1;
      if (r_valid && r_ready) begin
         r_nxt.bin  = r_r.bin + 1'b1;
         r_nxt.gray = r_nxt.bin ^ (r_nxt.bin >> 1);
      end
   end

   always_ff @(posedge wclk or negedge wrst_n) begin
      if (!wrst_n) w_r <= '0;
      else w_r <= w_nxt;
   end

   always_ff @(posedge wclk) begin
      if (w_valid && w_ready) mem[w_r.bin[AW-1:0]] <= w_data;
   end

   always_ff @(posedge rclk or negedge rrst_n) begin
      if (!rrst_n) r_r <= '0;
      else r_r <= r_nxt;
   end

   // Gray to binary, so the writer can see how many entries it believes are in use
   function automatic logic [AW:0] g2b(input logic [AW:0] g);
      logic [AW:0] b;
      b = g;
      for (int i = AW - 1; i >= 0; i--) b[i] = b[i+1] ^ g[i];
      return b;
   endfunction

   a_no_overrun: assert property (@(posedge wclk) disable iff (!wrst_n)
      (AW+1)'(w_r.bin - g2b(w_r.s2)) <= (AW+1)'(2 ** AW)) else $error("buffer holds more than its depth");
endmodule
`default_nettype wire

// ---- rtl/dcc_meas.sv ----
// Measurement kickoff sequencer: initialise, measure, optional post-processing, result load
`default_nettype none
module dcc_meas #(
   parameter int INIT_CYC = dcc_pkg::INIT_CYC,
   parameter int MEAS_CYC = dcc_pkg::MEAS_CYC,
   parameter int POST_CYC = dcc_pkg::POST_CYC
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Control
   input  wire logic kick,
   input  wire logic post_en,
   // Status
   output logic      meas_busy,
   output logic      init_act,
   output logic      result_upd
);
   typedef enum logic [2:0] {
      M_IDLE = 3'h0, M_INIT = 3'h1, M_MEAS = 3'h3, M_POST = 3'h2, M_LOAD = 3'h6
   } dcc_mst_t;
   typedef struct packed {
      dcc_mst_t                   st;
      logic [dcc_pkg::CNT_W-1:0]  cnt;
   } dcc_meas_t;
   dcc_meas_t m_r, m_nxt;

   localparam logic [dcc_pkg::CNT_W-1:0] C_INIT = dcc_pkg::CNT_W'(INIT_CYC - 1);
   localparam logic [dcc_pkg::CNT_W-1:0] C_MEAS = dcc_pkg::CNT_W'(MEAS_CYC - 1);
   localparam logic [dcc_pkg::CNT_W-1:0] C_POST = dcc_pkg::CNT_W'(POST_CYC - 1);

   assign meas_busy  = (m_r.st != M_IDLE);
   assign init_act   = (m_r.st == M_INIT);
   assign result_upd = (m_r.st == M_LOAD);

   always_comb begin
      m_nxt = m_r;
      m_nxt.cnt = m_r.cnt - 1'b1;
      unique case (m_r.st)
         M_IDLE: begin
            m_nxt.cnt = C_INIT;
            if (kick) m_nxt.st = M_INIT;
         end
         M_INIT: if (m_r.cnt == '0) begin
            m_nxt.st  = M_MEAS;
            m_nxt.cnt = C_MEAS;
         end
         M_MEAS: if (m_r.cnt == '0) begin
            m_nxt.st  = post_en ? M_POST : M_LOAD;
            m_nxt.cnt = C_POST;
         end
         M_POST: if (m_r.cnt == '0) m_nxt.st = M_LOAD;
         M_LOAD: m_nxt.st = M_IDLE;
         default: m_nxt.st = M_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) m_r <= '{st: M_IDLE, cnt: '0};
      else m_r <= m_nxt;
   end

   a_init_first: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(meas_busy) |-> init_act [*2]) else $error("measurement did not start with init");
   a_load_ends: assert property (@(posedge clock) disable iff (!rst_n)
      result_upd |=> !meas_busy) else $error("busy after result load");
endmodule
`default_nettype wire

// ---- rtl/dcc_chain.sv ----
// Daisy chain command relay, response clocking and measurement kickoff
`default_nettype none
module dcc_chain #(
   parameter int INIT_CYC = dcc_pkg::INIT_CYC,
   parameter int MEAS_CYC = dcc_pkg::MEAS_CYC,
   parameter int POST_CYC = dcc_pkg::POST_CYC
) (
   // System clock and reset
   input  wire logic                      clock,
   input  wire logic                      rstn,
   // Static configuration
   input  wire logic [dcc_pkg::POS_W-1:0] stack_pos,
   input  wire logic [dcc_pkg::POS_W-1:0] top_pos,
   input  wire logic [dcc_pkg::POS_W-1:0] target_pos,
   input  wire logic [2:0]                rsp_kind,
   input  wire logic                      post_en,
   // Host SPI pins
   input  wire logic                      spi_sck,
   input  wire logic                      spi_cs_n,
   input  wire logic                      spi_sdi,
   output logic                           drdy_n,
   // Measurement status
   output logic                           kick,
   output logic                           meas_busy,
   output logic                           result_upd,
   // Chain link
   input  wire logic                      dc_clk,
   input  wire logic                      dc_dn_frm,
   input  wire logic                      dc_dn_sdi,
   input  wire logic                      dc_up_frm,
   input  wire logic                      dc_up_sdi,
   output logic                           dc_up_sdo,
   output logic                           dc_up_oe,
   output logic                           dc_dn_sdo,
   output logic                           dc_dn_oe,
   output logic                           dc_clk_run,
   // Response data, chain clock domain
   input  wire logic                      rsp_go,
   input  wire logic [7:0]                rsp_byte,
   output logic                           rsp_take
);
   localparam int PW = dcc_pkg::POS_W;

   // ********************************
   // Decoders
   // ********************************
   function automatic logic is_meas_cmd(input logic [7:0] b);
      logic [3:0] op;
      op = b[dcc_pkg::OP_MSB:dcc_pkg::OP_LSB];
      return (op == dcc_pkg::OP_SCAN) || (op == dcc_pkg::OP_MEASURE);
   endfunction

   function automatic logic [5:0] resp_bytes(input logic [2:0] k);
      logic [5:0] n;
      n = dcc_pkg::LEN_REG;
      unique case (k)
         dcc_pkg::RSP_VOLT:  n = dcc_pkg::LEN_VOLT;
         dcc_pkg::RSP_TEMP:  n = dcc_pkg::LEN_TEMP;
         dcc_pkg::RSP_FAULT: n = dcc_pkg::LEN_FAULT;
         dcc_pkg::RSP_SETUP: n = dcc_pkg::LEN_SETUP;
         default:            n = dcc_pkg::LEN_REG;
      endcase
      return n;
   endfunction

   // ********************************
   // Reset release in each domain
   // ********************************
   logic [1:0] rs_sy, rs_lk;
   logic       rst_n, lrst_n;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) rs_sy <= 2'h0;
      else rs_sy <= {rs_sy[0], 1'b1};
   end
   always_ff @(posedge dc_clk or negedge rstn) begin
      if (!rstn) rs_lk <= 2'h0;
      else rs_lk <= {rs_lk[0], 1'b1};
   end
   assign rst_n  = rs_sy[1];
   assign lrst_n = rs_lk[1];

   logic is_master, is_top;
   assign is_master = (stack_pos == dcc_pkg::MASTER_POS);
   assign is_top    = (stack_pos == top_pos);

   // ********************************
   // Byte buffer between SPI side and chain side
   // ********************************
   logic       f_wvalid, f_wready, f_rvalid, f_rready;
   logic [8:0] f_wdata, f_rdata;

   // Chain domain state is declared here because the system domain samples its toggles
   typedef enum logic [1:0] {L_IDLE = 2'h0, L_SEND = 2'h1, L_ZERO = 2'h3, L_EXTRA = 2'h2} dcc_lst_t;
   typedef struct packed {
      dcc_lst_t   st;
      logic [7:0] sh;
      logic [2:0] bc;
      logic [PW-1:0] xc;
      logic       up_sdo, up_oe;
      logic [7:0] rx_sh;
      logic [2:0] rx_bc;
      logic       rx_first;
      logic       kick_t;
      logic [2:0] mr_bc;
      logic       drdy_t;
      logic       rsp_on;
      logic [8:0] rsp_bits;
      logic [PW-1:0] rsp_x;
      logic [7:0] rsp_sh;
      logic       dn_sdo, dn_oe;
   } dcc_lk_t;
   dcc_lk_t       lk_r, lk_nxt;
   dcc_afifo #(.W(9), .AW(1)) u_buf (
      .wclk(clock), .wrst_n(rst_n), .w_valid(f_wvalid), .w_data(f_wdata), .w_ready(f_wready),
      .rclk(dc_clk), .rrst_n(lrst_n), .r_valid(f_rvalid), .r_data(f_rdata), .r_ready(f_rready)
   );

   // ********************************
   // System domain: SPI receive, kickoff, data ready
   // ********************************
   typedef struct packed {
      logic       sck1, sck2, sck3;
      logic       cs1, cs2, cs3;
      logic       sdi1, sdi2;
      logic [7:0] sh;
      logic [2:0] bc;
      logic       first;
      logic       bpend, mpend;
      logic [7:0] bdata;
      logic       kt1, kt2, kt3;
      logic       dt1, dt2, dt3;
      logic       kick;
      logic       drdy_n;
   } dcc_sy_t;
   dcc_sy_t sy_r, sy_nxt;
   logic    sck_fall, sck_rise, cs_act;

   assign sck_fall = !sy_r.sck2 && sy_r.sck3;
   assign sck_rise = sy_r.sck2 && !sy_r.sck3;
   assign cs_act   = !sy_r.cs2 && is_master;
   assign f_wvalid = sy_r.bpend || sy_r.mpend;
   assign f_wdata  = sy_r.bpend ? {1'b0, sy_r.bdata} : {1'b1, dcc_pkg::BYTE_ZERO};

   always_comb begin
      sy_nxt = sy_r;
      {sy_nxt.sck1, sy_nxt.sck2, sy_nxt.sck3} = {spi_sck, sy_r.sck1, sy_r.sck2};
      {sy_nxt.cs1, sy_nxt.cs2, sy_nxt.cs3}    = {spi_cs_n, sy_r.cs1, sy_r.cs2};
      {sy_nxt.sdi1, sy_nxt.sdi2}              = {spi_sdi, sy_r.sdi1};
      {sy_nxt.kt1, sy_nxt.kt2, sy_nxt.kt3}    = {lk_r.kick_t, sy_r.kt1, sy_r.kt2};
      {sy_nxt.dt1, sy_nxt.dt2, sy_nxt.dt3}    = {lk_r.drdy_t, sy_r.dt1, sy_r.dt2};
      sy_nxt.kick = !is_master && (sy_r.kt2 ^ sy_r.kt3);
      if (f_wready && sy_r.bpend) sy_nxt.bpend = 1'b0;
      else if (f_wready && sy_r.mpend) sy_nxt.mpend = 1'b0;
      if (!cs_act) begin
         sy_nxt.bc    = '0;
         sy_nxt.first = 1'b1;
      end else if (sck_rise) begin
         sy_nxt.sh = {sy_r.sh[6:0], sy_r.sdi2};
      end else if (sck_fall) begin
         sy_nxt.bc = sy_r.bc + 1'b1;
         if (sy_r.bc == dcc_pkg::BIT_LAST) begin
            sy_nxt.first = 1'b0;
            if (sy_r.first && is_meas_cmd(sy_r.sh)) sy_nxt.kick = 1'b1;
            // relay once a full byte exists
            sy_nxt.bpend = 1'b1;
            sy_nxt.bdata = sy_r.sh;
         end
      end
      // Frame end marks the point where the zero byte is due
      if (sy_r.cs2 && !sy_r.cs3 && !sy_r.first && is_master) sy_nxt.mpend = 1'b1;
      if (!sy_r.cs2 && sy_r.cs3) sy_nxt.drdy_n = 1'b1;
      // response lowers data ready, lowering wins over the frame-start raise
      if (is_master && (sy_r.dt2 ^ sy_r.dt3)) sy_nxt.drdy_n = 1'b0;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sy_r        <= '0;
         sy_r.cs1    <= 1'b1;
         sy_r.cs2    <= 1'b1;
         sy_r.cs3    <= 1'b1;
         sy_r.first  <= 1'b1;
         sy_r.drdy_n <= 1'b1;
      end else begin
         sy_r <= sy_nxt;
      end
   end

   assign kick   = sy_r.kick;
   assign drdy_n = sy_r.drdy_n;

   dcc_meas #(.INIT_CYC(INIT_CYC), .MEAS_CYC(MEAS_CYC), .POST_CYC(POST_CYC)) u_meas (
      .clock(clock), .rst_n(rst_n), .kick(sy_r.kick), .post_en(post_en),
      .meas_busy(meas_busy), .init_act(), .result_upd(result_upd)
   );

   // ********************************
   // Chain domain: relay, forwarding, response clocking
   // ********************************
   logic [7:0]    rx_byte;
   logic [PW-1:0] rsp_extra;

   assign rx_byte = {lk_r.rx_sh[6:0], dc_dn_sdi};
   assign rsp_extra = !is_top ? stack_pos - dcc_pkg::POS_TWO :
                      (target_pos < top_pos) ? top_pos - target_pos - dcc_pkg::POS_ONE :
                      top_pos - dcc_pkg::POS_TWO;

   always_comb begin
      lk_nxt   = lk_r;
      f_rready = 1'b0;
      rsp_take = 1'b0;
      lk_nxt.bc = lk_r.bc + 1'b1;
      lk_nxt.sh = {lk_r.sh[6:0], 1'b0};
      unique case (lk_r.st)
         L_IDLE: if (is_master && f_rvalid) begin
            f_rready  = 1'b1;
            lk_nxt.bc = '0;
            // frame end sends a zero byte
            lk_nxt.st = f_rdata[8] ? L_ZERO : L_SEND;
            lk_nxt.sh = f_rdata[8] ? dcc_pkg::BYTE_ZERO : f_rdata[7:0];
         end
         L_SEND: if (lk_r.bc == dcc_pkg::BIT_LAST) lk_nxt.st = L_IDLE;
         L_ZERO: if (lk_r.bc == dcc_pkg::BIT_LAST) begin
            // then N-2 extra chain clocks
            // Outputs lag a cycle: the first extra cycle still carries the last zero bit
            lk_nxt.xc = (top_pos > dcc_pkg::POS_TWO) ? top_pos - dcc_pkg::POS_TWO : '0;
            lk_nxt.st = L_EXTRA;
         end
         L_EXTRA: begin
            lk_nxt.xc = lk_r.xc - 1'b1;
            if (lk_r.xc == '0) lk_nxt.st = L_IDLE;
         end
      endcase
      if (is_master) begin
         lk_nxt.up_oe  = (lk_r.st == L_SEND) || (lk_r.st == L_ZERO);
         lk_nxt.up_sdo = lk_nxt.up_oe && lk_r.sh[7];
      end else begin
         lk_nxt.up_oe  = dc_dn_frm;
         lk_nxt.up_sdo = dc_dn_sdi;
      end
      if (!dc_dn_frm || is_master) begin
         lk_nxt.rx_bc    = '0;
         lk_nxt.rx_first = 1'b1;
      end else begin
         lk_nxt.rx_sh = rx_byte;
         lk_nxt.rx_bc = lk_r.rx_bc + 1'b1;
         if (lk_r.rx_bc == dcc_pkg::BIT_LAST) begin
            lk_nxt.rx_first = 1'b0;
            // stack devices time from chain clock
            if (lk_r.rx_first && is_meas_cmd(rx_byte)) lk_nxt.kick_t = !lk_r.kick_t;
         end
      end
      lk_nxt.mr_bc = (is_master && dc_up_frm) ? lk_r.mr_bc + 1'b1 : 3'h0;
      if (is_master && dc_up_frm && lk_r.mr_bc == dcc_pkg::BIT_LAST) lk_nxt.drdy_t = !lk_r.drdy_t;
      lk_nxt.dn_oe  = 1'b0;
      lk_nxt.dn_sdo = 1'b0;
      if (!lk_r.rsp_on) begin
         if (rsp_go && !is_master) begin
            lk_nxt.rsp_on   = 1'b1;
            lk_nxt.rsp_bits = {resp_bytes(rsp_kind), 3'h0};
            lk_nxt.rsp_x    = rsp_extra;
            lk_nxt.rsp_sh   = rsp_byte;
            rsp_take        = 1'b1;
         end
      end else if (lk_r.rsp_bits != '0) begin
         lk_nxt.dn_oe    = 1'b1;
         lk_nxt.dn_sdo   = lk_r.rsp_sh[7];
         lk_nxt.rsp_sh   = {lk_r.rsp_sh[6:0], 1'b0};
         lk_nxt.rsp_bits = lk_r.rsp_bits - 1'b1;
         if (lk_r.rsp_bits[2:0] == dcc_pkg::BIT_ONE && lk_r.rsp_bits[8:3] != '0) begin
            lk_nxt.rsp_sh = rsp_byte;
            rsp_take      = 1'b1;
         end
      end else begin
         // The last bit stands in the first of these cycles, then rsp_x bare clocks follow
         lk_nxt.rsp_x = lk_r.rsp_x - 1'b1;
         if (lk_r.rsp_x == '0) lk_nxt.rsp_on = 1'b0;
      end
   end

   always_ff @(posedge dc_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         lk_r          <= '0;
         lk_r.st       <= L_IDLE;
         lk_r.rx_first <= 1'b1;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   assign dc_up_sdo  = lk_r.up_sdo;
   assign dc_up_oe   = lk_r.up_oe;
   assign dc_dn_sdo  = lk_r.dn_sdo;
   assign dc_dn_oe   = lk_r.dn_oe;
   // Keep the clock while a registered bit is still on a port, so it gets its edge
   assign dc_clk_run = (lk_r.st != L_IDLE) || lk_r.rsp_on || lk_r.up_oe || lk_r.dn_oe;

   // ********************************
   // Checks
   // ********************************
   a_kick_spi_edge: assert property (@(posedge clock) disable iff (!rst_n)
      (kick && is_master) |-> $past(sck_fall) && $past(sy_r.bc) == 3'h7) else $error("master kick off SPI edge");
   a_kick_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
      kick |=> !kick) else $error("kick longer than one cycle");
   a_relay_byte: assert property (@(posedge dc_clk) disable iff (!lrst_n)
      (lk_r.st == L_IDLE ##1 lk_r.st == L_SEND) |-> $past(f_rvalid) && !$past(f_rdata[8])) else $error("relay without byte");
   a_hop_delay: assert property (@(posedge dc_clk) disable iff (!lrst_n)
      !is_master |=> dc_up_sdo == $past(dc_dn_sdi)) else $error("forward delay not one cycle");
   a_zero_byte: assert property (@(posedge dc_clk) disable iff (!lrst_n)
      $rose(lk_r.st == L_ZERO) |-> lk_r.sh == 8'h00 ##1 lk_r.st == L_ZERO [*7]) else $error("zero byte wrong");
   a_extra_count: assert property (@(posedge dc_clk) disable iff (!lrst_n)
      (lk_r.st == L_EXTRA && $past(lk_r.st) == L_ZERO) |-> lk_r.xc == top_pos - 4'h2) else $error("extra clocks not N-2");
   a_rsp_extra: assert property (@(posedge dc_clk) disable iff (!lrst_n)
      ($rose(lk_r.rsp_on) && !is_top) |-> lk_r.rsp_x == stack_pos - 4'h2) else $error("middle extra not n-2");
   a_top_extra: assert property (@(posedge dc_clk) disable iff (!lrst_n)
      ($rose(lk_r.rsp_on) && is_top && target_pos < top_pos) |-> lk_r.rsp_x == top_pos - target_pos - 4'h1)
      else $error("top extra not N-n-1");
   a_drdy_low: assert property (@(posedge clock) disable iff (!rst_n)
      (is_master && (sy_r.dt2 ^ sy_r.dt3)) |=> !drdy_n) else $error("data ready not lowered");
endmodule
`default_nettype wire

// ---- test/dcc_peer.sv ----
// Neighbouring stack device model: gated link clock and one chain bit stream
`default_nettype none
module dcc_peer (
   // Link
   output logic      dc_clk,
   output logic      frm,
   output logic      sdi,
   // Control
   input  wire logic run,
   input  wire logic hold
);
   timeunit 1ns;
   timeprecision 100ps;
   logic en;
   // Link clock stands still outside a send and its 12-clock tail unless hold is set or the block asks for clocks
   initial begin
      dc_clk = 1'b0;
      frm = 1'b0;
      sdi = 1'b0;
      en = 1'b0;
      #1.7;
      forever begin
         #3;
         if (en || hold || run || dc_clk) dc_clk = ~dc_clk;
      end
   end
   // MSB first, one bit per link clock; a released line shows the inverse
   task automatic send(input logic [7:0] b);
      en = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         @(negedge dc_clk);
         frm <= 1'b1;
         sdi <= b[i];
      end
      @(negedge dc_clk);
      frm <= 1'b0;
      sdi <= ~b[0];
      // idle link clocks before next command
      repeat (12) @(negedge dc_clk);
      en = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- test/dcc_chain_bench.sv ----
// Self-checking bench for chain relay, responses and measurement kickoff
`default_nettype none
module dcc_chain_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock, rstn, sck, cs_n, sdi, rsp_go, hold, pen;
   logic [3:0]  spos, tpos, tgt;
   logic [2:0]  kind;
   logic [15:0] upq;
   logic [7:0]  rbyte, dnq;
   wire         dclk, frm, psdi, drdy_n, kick, busy, upd, up_sdo, up_oe, dn_sdo, dn_oe, run, take;
   int          fail_count, tests_run, nb, next, nexp, updc, tk;
   int          lens[5] = '{4, 40, 22, 22, 43};
   dcc_chain #(.INIT_CYC(4), .MEAS_CYC(20), .POST_CYC(4)) dcc_chain_inst (
      .clock(clock), .rstn(rstn), .stack_pos(spos), .top_pos(tpos), .target_pos(tgt),
      .rsp_kind(kind), .post_en(pen), .spi_sck(sck), .spi_cs_n(cs_n), .spi_sdi(sdi),
      .drdy_n(drdy_n), .kick(kick), .meas_busy(busy), .result_upd(upd), .dc_clk(dclk),
      .dc_dn_frm(frm & (spos != 4'h1)), .dc_dn_sdi(psdi), .dc_up_frm(frm & (spos == 4'h1)),
      .dc_up_sdi(psdi), .dc_up_sdo(up_sdo), .dc_up_oe(up_oe), .dc_dn_sdo(dn_sdo), .dc_dn_oe(dn_oe),
      .dc_clk_run(run), .rsp_go(rsp_go), .rsp_byte(rbyte), .rsp_take(take));
   dcc_peer dcc_peer_inst (.dc_clk(dclk), .frm(frm), .sdi(psdi), .run(run), .hold(hold));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Link-side observation: bits sent and extra clocks after the last bit
   always @(posedge dclk) begin
      if (up_oe) upq <= {upq[14:0], up_sdo};
      if (dn_oe) dnq <= {dnq[6:0], dn_sdo};
      if (take === 1'b1) tk <= tk + 1;
      if (up_oe || dn_oe) nb <= nb + 1;
      else if (run && nb == nexp) next <= next + 1;
   end
   always @(posedge clock) if (upd === 1'b1) updc <= updc + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic pick(input int s);
      return s == 0 ? kick === 1'b1 : s == 1 ? drdy_n === 1'b0 : nb >= nexp && !(up_oe | dn_oe | run);
   endfunction
   // Bounded wait; running out counts as a mismatch and ends the run
   task automatic waitc(input int s, input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(posedge clock);
         #1;
         if (pick(s)) return;
      end
      fail_count++;
      print_verdict();
   endtask
   task automatic setup(input logic [3:0] s, input logic [3:0] t);
      rstn <= 1'b0;
      spos <= s;
      tpos <= t;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      repeat (6) @(posedge clock);
   endtask
   task automatic spi_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clock) sdi <= b[i];
         repeat (4) @(posedge clock);
         sck <= 1'b1;
         repeat (4) @(posedge clock);
         sck <= 1'b0;
      end
   endtask
   task automatic t_master();
      int n;
      int cnt;
      setup(4'h1, 4'h4);
      nexp = 16;
      @(posedge clock) cs_n <= 1'b0;
      spi_byte(8'h1a);
      waitc(0, 10, n);
      check(n, 3);
      cnt = 0;
      repeat (60) begin
         @(posedge clock);
         #1;
         cnt += int'(busy === 1'b1);
      end
      check(cnt, 29);
      check(updc, 1);
      @(posedge clock) cs_n <= 1'b1;
      waitc(2, 900, n);
      check(upq, 16'h1a00);
      check(next, 2);
      hold <= 1'b0;
      dcc_peer_inst.send(8'h5c);
      waitc(1, 300, n);
      check(drdy_n, 1'b0);
      repeat (16) @(posedge clock);
      @(posedge clock) cs_n <= 1'b0;
      repeat (8) @(posedge clock);
      check(drdy_n, 1'b1);
      hold <= 1'b1;
   endtask
   // One response of kind k; x extra clocks expected after its last bit
   task automatic rsp_one(input int k, input int x);
      int n;
      @(posedge clock) kind <= 3'(k);
      nb <= 0;
      next <= 0;
      tk <= 0;
      nexp = lens[k] * 8;
      @(negedge dclk) rsp_go <= 1'b1;
      @(negedge dclk) rsp_go <= 1'b0;
      waitc(2, 3000, n);
      check(nb, nexp);
      check(tk, lens[k]);
      check(dnq, rbyte);
      check(next, x);
   endtask
   task automatic t_middle();
      int n;
      int cnt;
      pen <= 1'b0;
      setup(4'h3, 4'h5);
      nexp = 1000;
      cnt = 0;
      // The kick pulse comes while the peer is still clocking its tail
      fork
         dcc_peer_inst.send(8'h25);
         begin
            waitc(0, 200, n);
            check(kick, 1'b1);
            repeat (40) begin
               @(posedge clock);
               #1;
               cnt += int'(busy === 1'b1);
            end
         end
      join
      check(cnt, 25);
      check(upq[7:0], 8'h25);
      foreach (lens[k]) rsp_one(k, 1);
   endtask
   task automatic t_top();
      setup(4'h5, 4'h5);
      rbyte <= 8'h3c;
      rsp_one(0, 1);
   endtask
   initial begin
      {rstn, sck, sdi, rsp_go, kind, spos, tpos} = '0;
      {cs_n, hold} = 2'b11;
      {upq, nb, next, updc, nexp, tk, dnq} = '0;
      {pen, tgt, rbyte} = {1'b1, 4'h3, 8'ha5};
      fail_count = 0;
      tests_run = 0;
      t_master();
      t_middle();
      t_top();
      print_verdict();
   end
endmodule
`default_nettype wire
